// ===== serial_port_cfg_pkg.sv
// constants, field positions and state codes of the serial control port register block
// assumes nothing beyond a SystemVerilog tool; used by the register block only, the testbench uses literal values
package serial_port_cfg_pkg;

  localparam int ADDR_W  = 13;
  localparam int BYTE_W  = 8;
  localparam int INSTR_W = 16;

  // register offsets
  localparam logic [12:0] OFS_PORT_CFG = 13'h000;
  localparam logic [12:0] OFS_RB_SEL   = 13'h004;
  localparam logic [12:0] OFS_PWR_SYNC = 13'h230;
  localparam logic [12:0] OFS_RSVD_231 = 13'h231;
  localparam logic [12:0] OFS_COMMIT   = 13'h232;

  // reset values
  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_RB_SEL   = 8'h00;
  localparam logic [7:0] RST_PWR_SYNC = 8'h00;
  localparam logic [7:0] RST_COMMIT   = 8'h00;

  // field positions of serial_port_config
  localparam int BIT_PIN_EN     = 7;
  localparam int BIT_LSB_FIRST  = 6;
  localparam int BIT_SOFT_RST   = 5;
  localparam int BIT_LONG_INSTR = 4;

  // field positions of readback_bank_select and commit_buffered_values
  localparam int BIT_RB_ACTIVE = 0;
  localparam int BIT_COMMIT    = 0;

  // instruction word fields
  localparam int INSTR_RD_BIT  = 15;
  localparam int INSTR_LEN_HI  = 14;
  localparam int INSTR_LEN_LO  = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_INSTR = 5'h02,
    ST_WRITE = 5'h04,
    ST_READ  = 5'h08,
    ST_WAIT  = 5'h10
  } state_t;

endpackage

// ===== pin_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clk; stage one is read only by stage two
`timescale 1ns/10ps
module pin_sync #(
  parameter int     WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,   // system clock
  input  wire logic             nrst,  // async reset, active low
  input  wire logic             ce,    // clock enable
  input  wire logic [WIDTH-1:0] d,     // asynchronous inputs
  output logic      [WIDTH-1:0] q      // synchronised outputs
);

  logic [WIDTH-1:0] meta_r;

  generate
    if (WIDTH < 1)
    begin : g_bad_width
      $error("pin_sync: WIDTH must be at least 1");
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else if (ce)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule // pin_sync

// ===== serial_port_config_regs.sv
// serial control port slave with its configuration registers and buffered/active update
// assumes sclk half period of at least three clk cycles; pins are asynchronous to clk
//
// Summary of operation
// - with the output pin enable bit at 0, reads and writes use the two-way data pin and the read data pin floats.
// - with the output pin enable bit at 1, read data goes out on the read data pin and writes still enter on the data pin.
// - with bit order select at 0, bits move most significant first and the address steps down per byte.
// - with bit order select at 1, bits move least significant first and the address steps up per byte.
// - while the restore bit is 1 all other registers hold their defaults; it stays set until the host writes 0.
// - bit 0 of the readback select picks buffered values at 0 and active values at 1 for reads.
`timescale 1ns/10ps
module serial_port_config_regs (
  input  wire logic clk,              // system clock, 100 MHz
  input  wire logic nrst,             // async reset, active low
  input  wire logic ce,               // clock enable, freezes all state when low
  input  wire logic sclk,             // serial clock pin
  input  wire logic cs_n,             // chip select pin, active low
  input  wire logic sdio_in,          // two-way data pin, input side
  output logic      sdio_out,         // two-way data pin, output side
  output logic      sdio_oe_n,        // two-way data pin enable, low drives
  output logic      read_data_pin,    // read data pin value
  output logic      read_data_oe_n,   // read data pin enable, low drives
  output logic [7:0] pwr_sync_active  // active power down and sync value
);

  logic [2:0] pins_s;
  logic       sclk_d_r;
  serial_port_cfg_pkg::state_t state_r;
  logic [15:0] sh_r;
  logic [3:0]  cnt_r;
  logic [12:0] addr_r;
  logic [1:0]  len_r;
  logic [1:0]  bytes_r;
  logic        load_r;
  logic [7:0]  tx_r;
  logic [7:0]  port_cfg_r;
  logic [7:0]  rb_sel_r;
  logic [7:0]  pwr_buf_r;
  logic [7:0]  commit_r;

  pin_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h4)  // idle levels: chip select high, serial clock low, data low
  ) u_pin_sync (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .d    ({cs_n, sclk, sdio_in}),
    .q    (pins_s)
  );

  wire cs_n_s   = pins_s[2];
  wire sclk_s   = pins_s[1];
  wire din_s    = pins_s[0];
  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;

  wire lsb_first = port_cfg_r[serial_port_cfg_pkg::BIT_LSB_FIRST];
  wire pin_en    = port_cfg_r[serial_port_cfg_pkg::BIT_PIN_EN];
  wire soft_rst  = port_cfg_r[serial_port_cfg_pkg::BIT_SOFT_RST];
  wire rb_active = rb_sel_r[serial_port_cfg_pkg::BIT_RB_ACTIVE];
  wire do_commit = commit_r[serial_port_cfg_pkg::BIT_COMMIT];

  // shift in at the end for msb first, at the top for lsb first
  wire [15:0] sh_nxt = lsb_first ? {din_s, sh_r[15:1]} : {sh_r[14:0], din_s};
  wire [7:0]  byte_in = lsb_first ? sh_nxt[15:8] : sh_nxt[7:0];
  wire [12:0] addr_step = lsb_first ? addr_r + 13'h0001 : addr_r - 13'h0001;
  wire        tx_bit = lsb_first ? tx_r[0] : tx_r[7];
  wire [7:0]  tx_shift = lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};

  wire in_instr = (state_r == serial_port_cfg_pkg::ST_INSTR);
  wire in_write = (state_r == serial_port_cfg_pkg::ST_WRITE);
  wire in_read  = (state_r == serial_port_cfg_pkg::ST_READ);
  wire instr_done = in_instr & sclk_rise & (cnt_r == 4'hF);
  wire byte_done  = (in_write | in_read) & sclk_rise & (cnt_r == 4'h7);
  wire last_byte  = (len_r != serial_port_cfg_pkg::LEN_STREAM) & (bytes_r == len_r);
  wire wr_en      = in_write & byte_done;

  wire wr_cfg    = wr_en & (addr_r == serial_port_cfg_pkg::OFS_PORT_CFG);
  wire wr_rb     = wr_en & (addr_r == serial_port_cfg_pkg::OFS_RB_SEL);
  wire wr_pwr    = wr_en & (addr_r == serial_port_cfg_pkg::OFS_PWR_SYNC);
  wire wr_commit = wr_en & (addr_r == serial_port_cfg_pkg::OFS_COMMIT);

  // readback source follows the bank select for the buffered register
  wire [7:0] pwr_view = rb_active ? pwr_sync_active : pwr_buf_r;
  wire [7:0] rd_byte =
    (addr_r == serial_port_cfg_pkg::OFS_PORT_CFG) ? port_cfg_r :
    (addr_r == serial_port_cfg_pkg::OFS_RB_SEL)   ? rb_sel_r :
    (addr_r == serial_port_cfg_pkg::OFS_PWR_SYNC) ? pwr_view :
    (addr_r == serial_port_cfg_pkg::OFS_COMMIT)   ? commit_r : 8'h00;

  // transfer sequencing
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r  <= serial_port_cfg_pkg::ST_IDLE;
      sclk_d_r <= 1'b0;
      sh_r     <= 16'h0000;
      cnt_r    <= 4'h0;
      addr_r   <= 13'h0000;
      len_r    <= 2'h0;
      bytes_r  <= 2'h0;
      load_r   <= 1'b0;
    end
    else if (ce)
    begin
      sclk_d_r <= sclk_s;
      load_r   <= 1'b0;
      if (cs_n_s)
      begin
        state_r <= serial_port_cfg_pkg::ST_IDLE;
      end
      else
      begin
        unique case (state_r)
          serial_port_cfg_pkg::ST_IDLE:
          begin
            state_r <= serial_port_cfg_pkg::ST_INSTR;
            cnt_r   <= 4'h0;
          end
          serial_port_cfg_pkg::ST_INSTR:
          begin
            if (sclk_rise)
            begin
              sh_r  <= sh_nxt;
              cnt_r <= cnt_r + 4'h1;
            end
            // only the 16-bit instruction form is decoded
            if (instr_done)
            begin
              addr_r  <= sh_nxt[12:0];
              len_r   <= sh_nxt[serial_port_cfg_pkg::INSTR_LEN_HI:serial_port_cfg_pkg::INSTR_LEN_LO];
              bytes_r <= 2'h0;
              load_r  <= sh_nxt[serial_port_cfg_pkg::INSTR_RD_BIT];
              state_r <= sh_nxt[serial_port_cfg_pkg::INSTR_RD_BIT] ?
                         serial_port_cfg_pkg::ST_READ : serial_port_cfg_pkg::ST_WRITE;
            end
          end
          serial_port_cfg_pkg::ST_WRITE,
          serial_port_cfg_pkg::ST_READ:
          begin
            if (sclk_rise)
            begin
              sh_r  <= sh_nxt;
              cnt_r <= (cnt_r == 4'h7) ? 4'h0 : cnt_r + 4'h1;
            end
            if (byte_done)
            begin
              addr_r  <= addr_step;
              bytes_r <= bytes_r + 2'h1;
              load_r  <= in_read & ~last_byte;
              if (last_byte)
              begin
                state_r <= serial_port_cfg_pkg::ST_WAIT;
              end
            end
          end
          serial_port_cfg_pkg::ST_WAIT:
          begin
            state_r <= serial_port_cfg_pkg::ST_WAIT;
          end
        endcase
      end
    end
  end

  // read data shifter and pin drivers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_r           <= 8'h00;
      sdio_out       <= 1'b0;
      sdio_oe_n      <= 1'b1;
      read_data_pin  <= 1'b0;
      read_data_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      if (load_r)
      begin
        tx_r <= rd_byte;
      end
      else if (in_read & sclk_fall)
      begin
        tx_r          <= tx_shift;
        sdio_out      <= tx_bit;
        read_data_pin <= tx_bit;
        sdio_oe_n      <= pin_en;
        read_data_oe_n <= ~pin_en;
      end
      if (!in_read | cs_n_s)
      begin
        sdio_oe_n      <= 1'b1;
        read_data_oe_n <= 1'b1;
      end
    end
  end

  // register bank: restore holds others at default until the host clears it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      port_cfg_r      <= serial_port_cfg_pkg::RST_PORT_CFG;
      rb_sel_r        <= serial_port_cfg_pkg::RST_RB_SEL;
      pwr_buf_r       <= serial_port_cfg_pkg::RST_PWR_SYNC;
      pwr_sync_active <= serial_port_cfg_pkg::RST_PWR_SYNC;
      commit_r        <= serial_port_cfg_pkg::RST_COMMIT;
    end
    else if (ce)
    begin
      if (wr_cfg)
      begin
        port_cfg_r <= byte_in;
      end
      if (soft_rst)
      begin
        rb_sel_r        <= serial_port_cfg_pkg::RST_RB_SEL;
        pwr_buf_r       <= serial_port_cfg_pkg::RST_PWR_SYNC;
        pwr_sync_active <= serial_port_cfg_pkg::RST_PWR_SYNC;
        commit_r        <= serial_port_cfg_pkg::RST_COMMIT;
      end
      else
      begin
        if (wr_rb)
        begin
          rb_sel_r <= byte_in;
        end
        if (wr_pwr)
        begin
          pwr_buf_r <= byte_in;
        end
        // commit bit lives one cycle, then clears itself
        commit_r <= {7'h00, wr_commit & byte_in[serial_port_cfg_pkg::BIT_COMMIT]};
        if (do_commit)
        begin
          pwr_sync_active <= pwr_buf_r;
        end
      end
    end
  end

endmodule // serial_port_config_regs

// ===== serial_port_config_regs_properties.sv
// checker for the pin side of the serial port register block
// assumes the host keeps a frame open while a byte lands; checks pause while ce is low
`timescale 1ns/10ps
module serial_port_config_regs_properties (
  input wire logic       clk,             // system clock
  input wire logic       nrst,            // async reset, active low
  input wire logic       ce,              // clock enable
  input wire logic       sclk,            // serial clock pin
  input wire logic       cs_n,            // chip select pin
  input wire logic       sdio_in,         // two-way pin input side
  input wire logic       sdio_out,        // two-way pin output side
  input wire logic       sdio_oe_n,       // two-way pin enable
  input wire logic       read_data_pin,   // read data pin
  input wire logic       read_data_oe_n,  // read data pin enable
  input wire logic [7:0] pwr_sync_active  // active power down and sync
);
  sequence idle_s;
    cs_n [*5];
  endsequence
  sequence clk_high_s;
    (sclk && !cs_n) [*5];
  endsequence
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst || !ce);
  pin_excl_a: assert property (sdio_oe_n || read_data_oe_n) else $error("both data pins driven");
  idle_float_a: assert property (idle_s |-> sdio_oe_n && read_data_oe_n) else $error("pin driven while idle");
  bidir_drive_a: assert property ($fell(sdio_oe_n) |-> !cs_n && read_data_oe_n)
    else $error("two-way pin driven outside a frame");
  uni_drive_a: assert property ($fell(read_data_oe_n) |-> !cs_n && sdio_oe_n)
    else $error("read data pin driven outside a frame");
  pins_agree_a: assert property (!read_data_oe_n |-> read_data_pin == sdio_out) else $error("read pins disagree");
  bit_hold_a: assert property (clk_high_s |-> $stable(sdio_out)) else $error("read bit moved in high phase");
  commit_quiet_a: assert property (idle_s |-> $stable(pwr_sync_active)) else $error("active value moved idle");
  reset_clear_a: assert property ($rose(nrst) |-> pwr_sync_active == 8'h00) else $error("active value not reset");
endmodule // serial_port_config_regs_properties

bind serial_port_config_regs serial_port_config_regs_properties chk (.clk(clk), .nrst(nrst), .ce(ce), .sclk(sclk),
  .cs_n(cs_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .read_data_pin(read_data_pin),
  .read_data_oe_n(read_data_oe_n), .pwr_sync_active(pwr_sync_active));

// ===== host_model.sv
// host controller model driving the serial control port, mode 0 framing
// assumes it is called at falling clk edges; serial clock half period is six clk cycles
`timescale 1ns/10ps
module host_model (
  input  wire logic clk,             // system clock, paces the serial clock
  input  wire logic sdio_out,        // device side of the two-way pin
  input  wire logic sdio_oe_n,       // device drives two-way pin when low
  input  wire logic read_data_pin,   // read data pin
  input  wire logic read_data_oe_n,  // device drives read data pin when low
  output logic      sclk,            // serial clock, still outside frames
  output logic      cs_n,            // chip select, active low
  output logic      sdio_in          // resolved level of the two-way pin
);
  logic drv = 1'b0;
  logic uni = 1'b0;
  // no pull on the pins: a floating line reads as the inverse of the host value
  assign sdio_in = sdio_oe_n ? drv : sdio_out;
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    drv = b;
    repeat (5) @(negedge clk);
    if (uni)
      r = read_data_oe_n ? ~drv : read_data_pin;
    else
      r = sdio_oe_n ? ~drv : sdio_out;
    sclk = 1'b1;
    repeat (6) @(negedge clk);
    sclk = 1'b0;
    @(negedge clk);
  endtask
  task automatic byte_io(input logic [7:0] b, input logic lsb, input logic rel, output logic [7:0] r);
    logic t;
    for (int i = 0; i < 8; i++)
    begin
      bit_io(rel ? ~drv : b[lsb ? i : 7 - i], t);
      r[lsb ? i : 7 - i] = t;
    end
  endtask
  task automatic xfer(input logic [15:0] ins, input logic lsb, input int n, inout logic [31:0] d);
    logic [7:0] r;
    cs_n = 1'b0;
    repeat (3) @(negedge clk);
    byte_io(lsb ? ins[7:0] : ins[15:8], lsb, 1'b0, r);
    byte_io(lsb ? ins[15:8] : ins[7:0], lsb, 1'b0, r);
    for (int k = 0; k < n; k++)
    begin
      byte_io(d[8*k+:8], lsb, ins[15], r);
      if (ins[15])
        d[8*k+:8] = r;
    end
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule // host_model

// ===== serial_port_config_regs_test.sv
// self-checking testbench of the serial port register block
// assumes the host model for all pin traffic; ce is held high
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module serial_port_config_regs_test;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       lsb = 1'b0;
  logic       sclk, cs_n, sdio_in, sdio_out, sdio_oe_n, read_data_pin, read_data_oe_n;
  logic [7:0] pwr_sync_active;
  logic [31:0] d;
  int         n_fail = 0;
  int         checks = 0;
  always #5 clk = ~clk;
  serial_port_config_regs uut (.clk(clk), .nrst(nrst), .ce(1'b1), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
    .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .read_data_pin(read_data_pin), .read_data_oe_n(read_data_oe_n),
    .pwr_sync_active(pwr_sync_active));
  host_model host (.clk(clk), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .read_data_pin(read_data_pin),
    .read_data_oe_n(read_data_oe_n), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic acc(input logic rw, input logic [12:0] a, input int n, inout logic [31:0] v);
    host.xfer({rw, 2'(n - 1), a}, lsb, n, v);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] v);
    logic [31:0] t;
    t = {24'h000000, v};
    acc(1'b0, a, 1, t);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    logic [31:0] t;
    t = 32'h00000000;
    acc(1'b1, a, 1, t);
    `CHK("readback", e, t[7:0])
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial
  begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    rd(13'h000, 8'h18);
    rd(13'h004, 8'h00);
    rd(13'h230, 8'h00);
    rd(13'h232, 8'h00);
    wr(13'h231, 8'h5A);
    rd(13'h231, 8'h00);
    rd(13'h100, 8'h00);
    $display("test reset values done");
    wr(13'h230, 8'hA5);
    rd(13'h230, 8'hA5);
    `CHK("pwr_sync_active", 8'h00, pwr_sync_active)
    d = 32'h00000000;
    acc(1'b1, 13'h232, 4, d);
    `CHK("stream open down", 32'h00A50000, d)
    d = 32'h003CFF00;
    acc(1'b0, 13'h232, 3, d);
    d = 32'h00000000;
    acc(1'b1, 13'h232, 3, d);
    `CHK("stream down", 32'h003C0000, d)
    wr(13'h232, 8'h01);
    `CHK("pwr_sync_active", 8'h3C, pwr_sync_active)
    rd(13'h232, 8'h00);
    wr(13'h004, 8'h01);
    wr(13'h230, 8'hA5);
    rd(13'h230, 8'h3C);
    wr(13'h004, 8'h00);
    rd(13'h230, 8'hA5);
    $display("test buffered update done");
    wr(13'h000, 8'h5A);
    lsb = 1'b1;
    d = 32'h0000FF77;
    acc(1'b0, 13'h230, 3, d);
    d = 32'h00000000;
    acc(1'b1, 13'h230, 3, d);
    `CHK("stream up", 32'h00000077, d)
    rd(13'h000, 8'h5A);
    wr(13'h000, 8'hDB);
    host.uni = 1'b1;
    rd(13'h230, 8'h77);
    $display("test bit order and pins done");
    wr(13'h000, 8'hFF);
    rd(13'h000, 8'hFF);
    wr(13'h004, 8'h01);
    rd(13'h004, 8'h00);
    `CHK("pwr_sync_active", 8'h00, pwr_sync_active)
    wr(13'h000, 8'hDB);
    rd(13'h230, 8'h00);
    wr(13'h000, 8'h18);
    lsb = 1'b0;
    host.uni = 1'b0;
    rd(13'h000, 8'h18);
    $display("test soft restore done");
    give_verdict();
  end
endmodule // serial_port_config_regs_test
